// file: shared/dicd_pkg.sv
// package: frame layout, command codes and states for the drive io command decoder
package dicd_pkg;
  localparam int FRAME_BASE_BYTES = 12;
  localparam int FRAME_EXT_BYTES = 16;
  localparam int FRAME_MAX_BYTES = 16;
  localparam int BYTE_CMD_ID = 0;
  localparam int BYTE_TAG = 1;
  localparam int BYTE_STATUS_LO = 2;
  localparam int BYTE_STATUS_HI = 3;
  localparam int BYTE_DATA0 = 4;
  localparam int DATA_BYTES = 4;
  localparam logic [7:0] ID_ALARM_CLEAR = 8'h10;
  localparam logic [7:0] ID_POWER_ON = 8'h11;
  localparam logic [7:0] ID_POWER_OFF = 8'h12;
  localparam logic [7:0] ID_IO_READ = 8'h13;
  localparam logic [7:0] ID_IO_WRITE = 8'h14;
  localparam logic [7:0] ID_UNKNOWN_RESP = 8'h00;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] LEN_BASE = 5'h0C;
  localparam logic [4:0] LEN_EXT = 5'h10;
  typedef enum logic [1:0] {
    DICD_IDLE = 2'b00,
    DICD_RECV = 2'b01,
    DICD_WORK = 2'b11,
    DICD_SEND = 2'b10
  } dicd_state_t;
  typedef enum logic [1:0] {
    DICD_REQ_NONE = 2'b00,
    DICD_REQ_ALARM_CLEAR = 2'b01,
    DICD_REQ_POWER_ON = 2'b11,
    DICD_REQ_POWER_OFF = 2'b10
  } dicd_drive_req_t;
endpackage

// file: shared/dicd_link_if.sv
// interface: byte-wide command and response link between host and decoder
`timescale 1ns/10ps
interface dicd_link_if;
  logic [7:0] cmd_byte;
  logic cmd_valid;
  logic cmd_last;
  logic [7:0] rsp_byte;
  logic rsp_valid;
  logic rsp_last;
  logic ext_strap;
  modport dev (input cmd_byte, input cmd_valid, input cmd_last, input ext_strap,
    output rsp_byte, output rsp_valid, output rsp_last);
  modport host (output cmd_byte, output cmd_valid, output cmd_last, input ext_strap,
    input rsp_byte, input rsp_valid, input rsp_last);
endinterface

// file: core/dicd_device.sv
// device end: decodes command frames and builds response frames
`timescale 1ns/10ps
module dicd_device
  import dicd_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  dicd_link_if.dev link,
  input wire logic operational_in,
  input wire logic [15:0] drive_status_in,
  input wire logic [31:0] din_image_in,
  input wire logic bus_cycle_in,
  output logic [31:0] dout_image_out,
  output logic alarm_clear_cmd_out,
  output logic drive_power_on_cmd_out,
  output logic drive_power_off_cmd_out
);
  import dicd_pkg::*;

  dicd_state_t state;
  dicd_state_t next_state;
  dicd_drive_req_t pend;
  logic [7:0] cmd_mem [FRAME_MAX_BYTES];
  logic [7:0] rsp_mem [FRAME_MAX_BYTES];
  wire [7:0] rsp_img [FRAME_MAX_BYTES];
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [7:0] rsp_byte;
  logic rsp_valid;
  logic rsp_last;

  // frame length follows the strap
  wire [4:0] frame_len = link.ext_strap ? LEN_EXT : LEN_BASE;
  wire [4:0] last_idx = frame_len - CNT_ONE;
  wire byte_is_last = (cnt == last_idx);
  wire [7:0] cmd_id = cmd_mem[BYTE_CMD_ID];
  wire [7:0] cmd_tag = cmd_mem[BYTE_TAG];
  wire is_alm = operational_in && (cmd_id == ID_ALARM_CLEAR);
  wire is_on = operational_in && (cmd_id == ID_POWER_ON);
  wire is_off = operational_in && (cmd_id == ID_POWER_OFF);
  wire is_ird = operational_in && (cmd_id == ID_IO_READ);
  wire is_iwr = operational_in && (cmd_id == ID_IO_WRITE);
  wire is_drv = is_alm || is_on || is_off;
  wire accepted = is_drv || is_ird || is_iwr;
  wire sending = (state == DICD_SEND);
  wire working = (state == DICD_WORK);
  wire rx_take = (state == DICD_RECV || state == DICD_IDLE) && link.cmd_valid;
  // first byte clears leftovers of a cut-short frame
  wire rx_first = rx_take && (state == DICD_IDLE);
  // frame ends on its last flag or at the strap length
  wire rx_end = rx_take && (link.cmd_last || byte_is_last);
  // reserved command bytes are stored but never decoded
  wire [31:0] cmd_word = {cmd_mem[BYTE_DATA0 + 3], cmd_mem[BYTE_DATA0 + 2],
    cmd_mem[BYTE_DATA0 + 1], cmd_mem[BYTE_DATA0]};
  wire tx_end = sending && byte_is_last;
  // idle link carries zero, not the last byte sent
  wire [7:0] tx_byte = sending ? rsp_mem[cnt[3:0]] : 8'h00;

  // fields of the response image; reserved bytes stay zero
  wire [7:0] rsp_id_val = accepted ? cmd_id : ID_UNKNOWN_RESP;
  wire [7:0] rsp_tag_val = (is_drv || is_iwr) ? cmd_tag : 8'h00;
  wire [15:0] rsp_status_val = is_drv ? drive_status_in : 16'h0000;
  wire [31:0] rsp_data_val = is_ird ? din_image_in : 32'h0000_0000;

  // drive requests wait for the next bus cycle boundary
  wire dicd_drive_req_t req_decoded = is_alm ? DICD_REQ_ALARM_CLEAR :
    is_on ? DICD_REQ_POWER_ON : is_off ? DICD_REQ_POWER_OFF : DICD_REQ_NONE;
  // a request loaded now replaces one still waiting
  wire load_req = working && is_drv;
  wire issue_now = bus_cycle_in && (pend != DICD_REQ_NONE);
  wire fire = issue_now && !load_req;
  wire dicd_drive_req_t next_pend = load_req ? req_decoded :
    fire ? DICD_REQ_NONE : pend;
  wire pulse_alm = fire && (pend == DICD_REQ_ALARM_CLEAR);
  wire pulse_on = fire && (pend == DICD_REQ_POWER_ON);
  wire pulse_off = fire && (pend == DICD_REQ_POWER_OFF);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      // first byte may arrive straight from idle
      DICD_IDLE, DICD_RECV: begin
        if (rx_end) begin
          next_state = DICD_WORK;
          next_cnt = CNT_ZERO;
        end else if (rx_take) begin
          next_state = DICD_RECV;
          next_cnt = cnt + CNT_ONE;
        end
      end
      DICD_WORK: begin
        next_state = DICD_SEND;
        next_cnt = CNT_ZERO;
      end
      DICD_SEND: begin
        if (tx_end) begin
          next_state = DICD_IDLE;
          next_cnt = CNT_ZERO;
        end else begin
          next_cnt = cnt + CNT_ONE;
        end
      end
      default: begin
        next_state = DICD_IDLE;
        next_cnt = CNT_ZERO;
      end
    endcase
  end

  // register the machine; clock enable freezes it
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= DICD_IDLE;
      cnt <= CNT_ZERO;
    end else if (clk_en_in) begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // frame storage and response image per byte
  genvar gi;
  for (gi = 0; gi < FRAME_MAX_BYTES; gi++) begin : g_mem
    // bytes past the frame length are cleared on the first byte but never loaded from the link
    wire wr_here = rx_take && (cnt == 5'(gi));
    if (gi == BYTE_CMD_ID) begin : g_id
      assign rsp_img[gi] = rsp_id_val;
    end else if (gi == BYTE_TAG) begin : g_tag
      assign rsp_img[gi] = rsp_tag_val;
    end else if (gi == BYTE_STATUS_LO) begin : g_stlo
      assign rsp_img[gi] = rsp_status_val[7:0];
    end else if (gi == BYTE_STATUS_HI) begin : g_sthi
      assign rsp_img[gi] = rsp_status_val[15:8];
    end else if (gi >= BYTE_DATA0 && gi < BYTE_DATA0 + DATA_BYTES) begin : g_data
      assign rsp_img[gi] = rsp_data_val[8 * (gi - BYTE_DATA0) +: 8];
    end else begin : g_rsvd
      assign rsp_img[gi] = 8'h00;
    end
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        cmd_mem[gi] <= 8'h00;
        rsp_mem[gi] <= 8'h00;
      end else if (clk_en_in) begin
        if (rx_first) begin
          cmd_mem[gi] <= (gi == BYTE_CMD_ID) ? link.cmd_byte : 8'h00;
        end else if (wr_here) begin
          cmd_mem[gi] <= link.cmd_byte;
        end
        if (working) begin
          rsp_mem[gi] <= rsp_img[gi];
        end
      end
    end
  end

  // link outputs registered toward the host
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rsp_byte <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_last <= 1'b0;
    end else if (clk_en_in) begin
      rsp_valid <= sending;
      rsp_last <= tx_end;
      rsp_byte <= tx_byte;
    end
  end

  // output image changes only on an accepted write
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dout_image_out <= 32'h0000_0000;
    end else if (clk_en_in && working && is_iwr) begin
      dout_image_out <= cmd_word;
    end
  end

  // one-cycle pulses toward the slave
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pend <= DICD_REQ_NONE;
      alarm_clear_cmd_out <= 1'b0;
      drive_power_on_cmd_out <= 1'b0;
      drive_power_off_cmd_out <= 1'b0;
    end else if (clk_en_in) begin
      pend <= next_pend;
      alarm_clear_cmd_out <= pulse_alm;
      drive_power_on_cmd_out <= pulse_on;
      drive_power_off_cmd_out <= pulse_off;
    end
  end

  assign link.rsp_byte = rsp_byte;
  assign link.rsp_valid = rsp_valid;
  assign link.rsp_last = rsp_last;
endmodule

// file: core/dicd_host.sv
// host end: sends one command frame and collects the response frame
`timescale 1ns/10ps
module dicd_host
  import dicd_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  dicd_link_if.host link,
  input wire logic start_in,
  input wire logic [7:0] cmd_id_in,
  input wire logic [7:0] tag_in,
  input wire logic [31:0] data_in,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] rsp_id_out,
  output logic [7:0] rsp_tag_out,
  output logic [15:0] rsp_status_out,
  output logic [31:0] rsp_data_out
);
  import dicd_pkg::*;

  dicd_state_t state;
  logic [4:0] cnt;
  logic [7:0] id_q;
  logic [7:0] tag_q;
  logic [31:0] data_q;
  logic [7:0] cmd_byte;
  logic cmd_valid;
  logic cmd_last;

  // frame ends at byte 11 unless the strap is high
  wire [4:0] frame_len = link.ext_strap ? LEN_EXT : LEN_BASE;
  wire [4:0] last_idx = frame_len - CNT_ONE;
  wire sending = (state == DICD_SEND);
  wire [4:0] data_off = cnt - BYTE_DATA0[4:0];
  // reserved bytes sent as zero
  wire [7:0] tx_val = (cnt == BYTE_CMD_ID[4:0]) ? id_q :
    (cnt == BYTE_TAG[4:0]) ? tag_q :
    (cnt >= BYTE_DATA0[4:0] && data_off < DATA_BYTES[4:0]) ?
    data_q[8 * data_off[1:0] +: 8] : 8'h00;
  wire rx = (state == DICD_RECV) && link.rsp_valid;
  wire [4:0] rx_idx = cnt;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= DICD_IDLE;
      cnt <= CNT_ZERO;
      id_q <= 8'h00;
      tag_q <= 8'h00;
      data_q <= 32'h0000_0000;
      cmd_byte <= 8'h00;
      cmd_valid <= 1'b0;
      cmd_last <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      rsp_id_out <= 8'h00;
      rsp_tag_out <= 8'h00;
      rsp_status_out <= 16'h0000;
      rsp_data_out <= 32'h0000_0000;
    end else if (clk_en_in) begin
      done_out <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_last <= 1'b0;
      case (state)
        DICD_IDLE: begin
          if (start_in) begin
            id_q <= cmd_id_in;
            tag_q <= tag_in;
            data_q <= data_in;
            cnt <= CNT_ZERO;
            busy_out <= 1'b1;
            state <= DICD_SEND;
          end
        end
        DICD_SEND: begin
          cmd_byte <= tx_val;
          cmd_valid <= 1'b1;
          cmd_last <= (cnt == last_idx);
          if (cnt == last_idx) begin
            cnt <= CNT_ZERO;
            state <= DICD_RECV;
          end else begin
            cnt <= cnt + CNT_ONE;
          end
        end
        DICD_RECV: begin
          if (rx) begin
            if (rx_idx == BYTE_CMD_ID[4:0]) rsp_id_out <= link.rsp_byte;
            if (rx_idx == BYTE_TAG[4:0]) rsp_tag_out <= link.rsp_byte;
            if (rx_idx == BYTE_STATUS_LO[4:0]) rsp_status_out[7:0] <= link.rsp_byte;
            if (rx_idx == BYTE_STATUS_HI[4:0]) rsp_status_out[15:8] <= link.rsp_byte;
            if (rx_idx >= BYTE_DATA0[4:0] && data_off < DATA_BYTES[4:0]) begin
              rsp_data_out[8 * data_off[1:0] +: 8] <= link.rsp_byte;
            end
            cnt <= cnt + CNT_ONE;
            if (link.rsp_last) begin
              state <= DICD_IDLE;
              busy_out <= 1'b0;
              done_out <= 1'b1;
            end
          end
        end
        default: begin
          state <= DICD_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  assign link.cmd_byte = cmd_byte;
  assign link.cmd_valid = cmd_valid;
  assign link.cmd_last = cmd_last;
endmodule

// file: verif/dicd_link_chk.sv
// checker: framing and content rules on the command and response link
`timescale 1ns/10ps
module dicd_link_chk (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_valid,
  input wire logic cmd_last,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic ext_strap
);
  logic [4:0] rcnt;
  logic [4:0] ccnt;
  logic [7:0] ctag;
  logic [7:0] rid;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rcnt <= 5'h00;
      ccnt <= 5'h00;
      ctag <= 8'h00;
      rid <= 8'h00;
    end else begin
      if (rsp_valid) rcnt <= rsp_last ? 5'h00 : rcnt + 5'h01;
      if (cmd_valid) ccnt <= cmd_last ? 5'h00 : ccnt + 5'h01;
      if (cmd_valid && ccnt == 5'h01) ctag <= cmd_byte;
      if (rsp_valid && rcnt == 5'h00) rid <= rsp_byte;
    end
  end
  sequence s_cmd_end;
    cmd_valid && cmd_last;
  endsequence
  sequence s_tag_byte;
    rsp_valid && rcnt == 5'h01 && rid inside {8'h10, 8'h11, 8'h12, 8'h14};
  endsequence
  last_has_valid_a: assert property (rsp_last |-> rsp_valid)
    else $error("response last without valid");
  rsp_length_a: assert property (rsp_last |-> rcnt == (ext_strap ? 5'h0F : 5'h0B))
    else $error("response frame length wrong");
  cmd_length_a: assert property (s_cmd_end |-> ccnt == (ext_strap ? 5'h0F : 5'h0B))
    else $error("command frame length wrong");
  rsp_start_a: assert property (s_cmd_end |-> ##[3:4] rsp_valid)
    else $error("response did not start in time");
  rsp_burst_a: assert property (rsp_valid && !rsp_last |=> rsp_valid)
    else $error("response frame has a gap");
  rsp_gap_a: assert property (rsp_last |=> !rsp_valid)
    else $error("response runs past last byte");
  reserved_zero_a: assert property (rsp_valid && rcnt >= 5'h08 |-> rsp_byte == 8'h00)
    else $error("reserved response byte not zero");
  id_legal_a: assert property (rsp_valid && rcnt == 5'h00 |->
    rsp_byte inside {8'h00, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14})
    else $error("response identifier illegal");
  tag_echo_a: assert property (s_tag_byte |-> rsp_byte == ctag)
    else $error("request tag not echoed");
endmodule

// file: verif/drive_io_command_decoder_tb.sv
// testbench: host end and device end joined, whole command set exercised
`timescale 1ns/10ps
module drive_io_command_decoder_tb;
  import dicd_pkg::*;
  logic core_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic operational = 1'b0;
  logic [15:0] drive_status = 16'hA5C3;
  logic [31:0] din_image = 32'h8765_4321;
  logic bus_cycle = 1'b0;
  logic start = 1'b0;
  logic [7:0] cmd_id = 8'h00;
  logic [7:0] tag = 8'h00;
  logic [31:0] data = 32'h0000_0000;
  logic [31:0] exp_dout = 32'h0000_0000;
  wire busy, done, aclr, pon, poff;
  wire [7:0] rsp_id, rsp_tag;
  wire [15:0] rsp_status;
  wire [31:0] rsp_data, dout;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int pcnt [3] = '{0, 0, 0};
  int epc [3] = '{0, 0, 0};
  dicd_link_if link ();
  dicd_device i_dicd_device (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .clk_en_in(1'b1),
    .link(link), .operational_in(operational), .drive_status_in(drive_status),
    .din_image_in(din_image), .bus_cycle_in(bus_cycle), .dout_image_out(dout),
    .alarm_clear_cmd_out(aclr), .drive_power_on_cmd_out(pon), .drive_power_off_cmd_out(poff));
  dicd_host i_dicd_host (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .clk_en_in(1'b1),
    .link(link), .start_in(start), .cmd_id_in(cmd_id), .tag_in(tag), .data_in(data),
    .busy_out(busy), .done_out(done), .rsp_id_out(rsp_id), .rsp_tag_out(rsp_tag),
    .rsp_status_out(rsp_status), .rsp_data_out(rsp_data));
  dicd_link_chk i_dicd_link_chk (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .cmd_byte(link.cmd_byte), .cmd_valid(link.cmd_valid), .cmd_last(link.cmd_last),
    .rsp_byte(link.rsp_byte), .rsp_valid(link.rsp_valid), .rsp_last(link.rsp_last),
    .ext_strap(link.ext_strap));
  always #12.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cycles++;
    if (aclr === 1'b1) pcnt[0]++;
    if (pon === 1'b1) pcnt[1]++;
    if (poff === 1'b1) pcnt[2]++;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task chk_pulses;
    for (int k = 0; k < 3; k++) check(pcnt[k], epc[k]);
  endtask
  task run(input logic [7:0] id, input logic [7:0] t, input logic [31:0] d);
    int n;
    logic acc;
    @(posedge core_clk_in);
    acc = operational && id >= 8'h10 && id <= 8'h14;
    start <= 1'b1;
    cmd_id <= id;
    tag <= t;
    data <= d;
    @(posedge core_clk_in);
    start <= 1'b0;
    #1;
    check({31'h0, busy}, 32'h1);
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    check({31'h0, done}, 32'h1);
    check({31'h0, busy}, 32'h0);
    check(rsp_id, acc ? id : 8'h00);
    check(rsp_tag, (acc && id != 8'h13) ? t : 8'h00);
    check(rsp_status, (acc && id <= 8'h12) ? drive_status : 16'h0000);
    check(rsp_data, (acc && id == 8'h13) ? din_image : 32'h0);
    if (acc && id == 8'h14) exp_dout = d;
    check(dout, exp_dout);
    chk_pulses();
    if (acc && id <= 8'h12) epc[id - 8'h10]++;
    @(posedge core_clk_in);
    bus_cycle <= 1'b1;
    @(posedge core_clk_in);
    bus_cycle <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk_pulses();
  endtask
  initial begin
    link.ext_strap = 1'b0;
    repeat (4) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    operational <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk_in);
      link.ext_strap <= s[0];
      for (int i = 0; i < 6; i++) run(8'h10 + i, 8'h3C + i, 32'h9ABC_DE00 + i + 16 * s);
    end
    @(posedge core_clk_in);
    operational <= 1'b0;
    run(8'h11, 8'h5A, 32'h0);
    run(8'h14, 8'h77, 32'h1234_5678);
    final_report();
  end
endmodule
